/* pkg/mqf_defs.svh */
// Constants shared by both ends of the multi-queue FIFO link
// Assumes inclusion by bare name from design files
`ifndef MQF_DEFS_SVH
`define MQF_DEFS_SVH
// ----------------------------------------
// Queue pool
// ----------------------------------------
`define MQF_NQ 16
`define MQF_UNITS 16384
`define MQF_DEF_NQ 5'h10
`define MQF_DEF_BLK 5'h01
`define MQF_DEF_AF 14'h0010
`define MQF_DEF_AE 14'h0010
`define MQF_SECTOR_MAX 5'h08
// ----------------------------------------
// Serial frame and timing
// ----------------------------------------
`define MQF_FRAME_LAST 6'h29
`define MQF_MRS_CYC 3'h4
// ----------------------------------------
// Host register map (byte addresses)
// ----------------------------------------
`define MQF_A_CTRL 5'h00
`define MQF_A_SEL 5'h04
`define MQF_A_FRM_LO 5'h08
`define MQF_A_FRM_HI 5'h0c
`define MQF_A_STAT 5'h10
`define MQF_A_MASK 5'h14
`define MQF_A_FLAGS 5'h18
`define MQF_CTRL_MRS 0
`define MQF_CTRL_PRS 1
`define MQF_CTRL_SEND 2
`define MQF_CTRL_BUSY 3
`define MQF_CTRL_STRAP_LSB 4
`define MQF_STRAP_RST 6'h00
`define MQF_ST_RESET 0
`define MQF_ST_FRAME 1
`define MQF_ST_DROP 2
`define MQF_ST_AF 3
`endif

/* pkg/mqf_pkg.sv */
// Types shared by the multi-queue FIFO ends
// Assumes nothing of its surroundings
package mqf_pkg;
    typedef struct packed {
        logic [4:0] nq;
        logic [3:0] idx;
        logic [4:0] blk;
        logic [13:0] af;
        logic [13:0] ae;
    } mqf_frame_t;
    typedef enum logic [1:0] {st_idle, st_mrst, st_shift} mqf_hstate_t;
endpackage

/* pkg/mqf_link_if.sv */
// Link between the queue device and its writer/reader controller
// Assumes both ends run on one common clock
`timescale 1ns/1ps
`default_nettype none
interface mqf_link_if;
    logic master_reset_n, partial_reset_n;
    logic cfg_in_wide, cfg_out_wide, cfg_polled;
    logic [2:0] cfg_dev_id;
    logic ser_en, ser_data;
    logic [6:0] write_queue_select, read_queue_select;
    logic wr_en, rd_en, rd_data_oe;
    logic [17:0] wr_data, rd_data;
    logic queue_full_flag, almost_full_flag;
    logic output_valid_flag, almost_empty_flag;
    logic [7:0] af_bus, ae_bus;
    logic af_sector, ae_sector, af_sector_sel, ae_sector_sel;
    modport dev (
        input master_reset_n, partial_reset_n, cfg_in_wide, cfg_out_wide, cfg_polled, cfg_dev_id,
        input ser_en, ser_data, write_queue_select, read_queue_select, wr_en, rd_en, wr_data,
        input af_sector_sel, ae_sector_sel,
        output rd_data, rd_data_oe, queue_full_flag, almost_full_flag, output_valid_flag,
        output almost_empty_flag, af_bus, ae_bus, af_sector, ae_sector
    );
    modport host (
        output master_reset_n, partial_reset_n, cfg_in_wide, cfg_out_wide, cfg_polled, cfg_dev_id,
        output ser_en, ser_data, write_queue_select, read_queue_select, wr_en, rd_en, wr_data,
        output af_sector_sel, ae_sector_sel,
        input rd_data, rd_data_oe, queue_full_flag, almost_full_flag, output_valid_flag,
        input almost_empty_flag, af_bus, ae_bus, af_sector, ae_sector
    );
endinterface
`default_nettype wire

/* verilog/mqf_ser_rx.sv */
// Serial programming receiver of the queue device
// Assumes ser_en stays high for one whole frame, MSB first
`timescale 1ns/1ps
`default_nettype none
`include "mqf_defs.svh"
module mqf_ser_rx (
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, low
    input wire logic enable, // Frames accepted
    input wire logic ser_en, // Frame in progress
    input wire logic ser_data, // Serial bit
    output mqf_pkg::mqf_frame_t frame, // Received frame
    output logic frame_stb // Frame complete pulse
);
    logic [41:0] sh_q;
    logic [5:0] cnt_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sh_q <= 42'h0;
            cnt_q <= 6'h00;
            frame_stb <= 1'b0;
        end else begin
            frame_stb <= 1'b0;
            if (!enable || !ser_en) begin
                cnt_q <= 6'h00;
            end else begin
                sh_q <= {sh_q[40:0], ser_data};
                if (cnt_q == `MQF_FRAME_LAST) begin
                    cnt_q <= 6'h00;
                    frame_stb <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 6'h01;
                end
            end
        end
    end

    assign frame = mqf_pkg::mqf_frame_t'(sh_q);
endmodule // mqf_ser_rx
`default_nettype wire

/* verilog/mqf_device.sv */
// Multi-queue FIFO device end: shared pool, queue flags, flag buses
// Assumes the controller end drives the link on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "mqf_defs.svh"
module mqf_device (
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, low
    mqf_link_if.dev lnk, // Link to controller
    output logic prog_ok, // Programming allowed
    output logic [4:0] queue_count // Configured queues
);
    localparam int NQ = `MQF_NQ;

    // ----------------------------------------
    // Storage and per-queue views
    // ----------------------------------------
    logic [8:0] mem [0:`MQF_UNITS-1];
    logic [14:0] base [NQ+1];
    logic [14:0] depth [NQ];
    logic [14:0] cnt [NQ];
    logic [14:0] cnt_d [NQ];
    logic [13:0] wp [NQ];
    logic [13:0] rp [NQ];
    logic [NQ-1:0] af_v, ae_v;

    logic in_wide_q, out_wide_q, polled_q, prog_ok_q;
    logic [2:0] id_q;
    logic [4:0] nq_q;
    logic mrs_n, prs_n, clr_all, prs_hit;
    logic [14:0] wu, ru;
    logic [3:0] wq, rq;
    logic w_own, r_own, wr_ok, take, need, sw;
    logic [6:0] cur_rsel_q;
    logic ov_q, oe_q, full_q, af_q, ae_q;
    logic [17:0] dout_q;
    logic af_sec_q, ae_sec_q, af_sec_d, ae_sec_d;
    logic [7:0] af_bus_q, ae_bus_q;
    mqf_pkg::mqf_frame_t frm;
    logic frm_stb;

    function automatic logic [13:0] adv(input logic [13:0] p, input logic [14:0] n, input logic [14:0] d);
        logic [14:0] s;
        s = {1'b0, p} + n;
        if (s >= d) begin
            s = s - d;
        end
        return s[13:0];
    endfunction

    // ----------------------------------------
    // Master reset and straps
    // ----------------------------------------
    assign mrs_n = lnk.master_reset_n;
    assign prs_n = lnk.partial_reset_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_wide_q <= 1'b0;
            out_wide_q <= 1'b0;
            polled_q <= 1'b0;
            id_q <= 3'h0;
            prog_ok_q <= 1'b0;
        end else if (!mrs_n) begin
            in_wide_q <= lnk.cfg_in_wide;
            out_wide_q <= lnk.cfg_out_wide;
            polled_q <= lnk.cfg_polled;
            id_q <= lnk.cfg_dev_id;
            prog_ok_q <= 1'b1;
        end
    end

    mqf_ser_rx u_ser (
        .clk(clk),
        .rstn(rstn),
        .enable(prog_ok_q && mrs_n),
        .ser_en(lnk.ser_en),
        .ser_data(lnk.ser_data),
        .frame(frm),
        .frame_stb(frm_stb)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nq_q <= `MQF_DEF_NQ;
        end else if (!mrs_n) begin
            nq_q <= `MQF_DEF_NQ;
        end else if (frm_stb) begin
            nq_q <= frm.nq;
        end
    end

    // ----------------------------------------
    // Port selects and transfer decisions
    // ----------------------------------------
    assign wu = in_wide_q ? 15'h0002 : 15'h0001;
    assign ru = out_wide_q ? 15'h0002 : 15'h0001;
    assign wq = lnk.write_queue_select[3:0];
    assign rq = lnk.read_queue_select[3:0];
    assign w_own = lnk.write_queue_select[6:4] == id_q && {1'b0, wq} < nq_q;
    assign r_own = lnk.read_queue_select[6:4] == id_q && {1'b0, rq} < nq_q;
    assign clr_all = !mrs_n || frm_stb;
    assign prs_hit = !prs_n && w_own && lnk.write_queue_select == lnk.read_queue_select;

    assign wr_ok = lnk.wr_en && w_own && mrs_n && prs_n && (depth[wq] - cnt[wq] >= wu);
    assign sw = lnk.read_queue_select != cur_rsel_q;
    assign need = sw || !ov_q || lnk.rd_en;
    assign take = r_own && need && mrs_n && prs_n && cnt[rq] >= ru;

    assign base[0] = 15'h0000;

    // ----------------------------------------
    // Per-queue layout, pointers and levels
    // ----------------------------------------
    for (genvar i = 0; i < NQ; i++) begin : g_q
        logic [4:0] blk_q;
        logic [13:0] afo_q, aeo_q, wp_q, rp_q;
        logic [14:0] cnt_q;
        logic w_i, r_i, clr_i, live_i;

        assign live_i = 5'(i) < nq_q;
        assign w_i = wr_ok && wq == 4'(i);
        assign r_i = take && rq == 4'(i);
        assign clr_i = clr_all || (prs_hit && wq == 4'(i));
        assign depth[i] = {blk_q, 10'h000};
        assign base[i+1] = base[i] + depth[i];
        assign cnt_d[i] = clr_i ? 15'h0000 : cnt_q + (w_i ? wu : 15'h0000) - (r_i ? ru : 15'h0000);
        assign cnt[i] = cnt_q;
        assign wp[i] = wp_q;
        assign rp[i] = rp_q;
        assign af_v[i] = live_i && (cnt_d[i] + {1'b0, afo_q} >= depth[i]);
        assign ae_v[i] = live_i && (cnt_d[i] <= {1'b0, aeo_q});

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                blk_q <= `MQF_DEF_BLK;
                afo_q <= `MQF_DEF_AF;
                aeo_q <= `MQF_DEF_AE;
            end else if (!mrs_n) begin
                blk_q <= `MQF_DEF_BLK;
                afo_q <= `MQF_DEF_AF;
                aeo_q <= `MQF_DEF_AE;
            end else if (frm_stb && frm.idx == 4'(i)) begin
                blk_q <= frm.blk;
                afo_q <= frm.af;
                aeo_q <= frm.ae;
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                wp_q <= 14'h0000;
                rp_q <= 14'h0000;
                cnt_q <= 15'h0000;
            end else begin
                cnt_q <= cnt_d[i];
                if (clr_i) begin
                    wp_q <= 14'h0000;
                    rp_q <= 14'h0000;
                end else begin
                    if (w_i) begin
                        wp_q <= adv(wp_q, wu, depth[i]);
                    end
                    if (r_i) begin
                        rp_q <= adv(rp_q, ru, depth[i]);
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Shared memory, low byte first
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (wr_ok) begin
            mem[14'(base[wq] + {1'b0, wp[wq]})] <= lnk.wr_data[8:0];
            if (in_wide_q) begin
                mem[14'(base[wq] + {1'b0, adv(wp[wq], 15'h0001, depth[wq])})] <= lnk.wr_data[17:9];
            end
        end
    end

    // ----------------------------------------
    // Fall-through output register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ov_q <= 1'b0;
            dout_q <= 18'h00000;
            cur_rsel_q <= 7'h00;
            oe_q <= 1'b0;
        end else begin
            cur_rsel_q <= lnk.read_queue_select;
            oe_q <= lnk.read_queue_select[6:4] == id_q;
            if (!mrs_n || prs_hit) begin
                ov_q <= 1'b0;
            end else if (take) begin
                ov_q <= 1'b1;
                if (out_wide_q) begin
                    dout_q <= {mem[14'(base[rq] + {1'b0, adv(rp[rq], 15'h0001, depth[rq])})],
                               mem[14'(base[rq] + {1'b0, rp[rq]})]};
                end else begin
                    dout_q <= {9'h000, mem[14'(base[rq] + {1'b0, rp[rq]})]};
                end
            end else if (need) begin
                ov_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Selected-queue flags
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            full_q <= 1'b1;
            af_q <= 1'b0;
            ae_q <= 1'b1;
        end else begin
            full_q <= !w_own || (depth[wq] - cnt_d[wq] < wu);
            af_q <= !w_own || af_v[wq];
            ae_q <= !r_own || ae_v[rq];
        end
    end

    // ----------------------------------------
    // Flag status buses
    // ----------------------------------------
    always_comb begin
        if (nq_q <= `MQF_SECTOR_MAX) begin
            af_sec_d = 1'b0;
            ae_sec_d = 1'b0;
        end else if (polled_q) begin
            af_sec_d = ~af_sec_q;
            ae_sec_d = ~ae_sec_q;
        end else begin
            af_sec_d = lnk.af_sector_sel;
            ae_sec_d = lnk.ae_sector_sel;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            af_sec_q <= 1'b0;
            ae_sec_q <= 1'b0;
            af_bus_q <= 8'h00;
            ae_bus_q <= 8'h00;
        end else begin
            af_sec_q <= af_sec_d;
            ae_sec_q <= ae_sec_d;
            af_bus_q <= af_sec_d ? af_v[15:8] : af_v[7:0];
            ae_bus_q <= ae_sec_d ? ae_v[15:8] : ae_v[7:0];
        end
    end

    assign lnk.rd_data = dout_q;
    assign lnk.rd_data_oe = oe_q;
    assign lnk.output_valid_flag = ov_q;
    assign lnk.queue_full_flag = full_q;
    assign lnk.almost_full_flag = af_q;
    assign lnk.almost_empty_flag = ae_q;
    assign lnk.af_bus = af_bus_q;
    assign lnk.ae_bus = ae_bus_q;
    assign lnk.af_sector = af_sec_q;
    assign lnk.ae_sector = ae_sec_q;
    assign prog_ok = prog_ok_q;
    assign queue_count = nq_q;
endmodule // mqf_device
`default_nettype wire

/* verilog/mqf_host.sv */
// Multi-queue FIFO controller end: register port, serial setup, stream
// Assumes the device end on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "mqf_defs.svh"
module mqf_host (
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, low
    mqf_link_if.host lnk, // Link to device
    input wire logic [4:0] addr, // Register address
    input wire logic [31:0] wdata, // Write data
    input wire logic we, // Write strobe
    input wire logic re, // Read strobe
    output logic [31:0] rdata, // Read data, next cycle
    output logic irq, // Interrupt, high
    input wire logic up_valid, // Upstream word valid
    input wire logic [17:0] up_data, // Upstream word
    output logic up_ready, // Upstream may send
    input wire logic dn_ready, // Downstream drains
    output logic [17:0] dn_data, // Downstream word
    output logic dn_valid // Downstream word valid
);
    mqf_pkg::mqf_hstate_t st_q;
    logic [5:0] strap_q;
    logic [17:0] sel_q;
    logic [27:0] flo_q;
    logic [13:0] fhi_q;
    logic [3:0] stat_q, mask_q, ev;
    logic [41:0] sh_q;
    logic [5:0] bit_q;
    logic [2:0] mcnt_q;
    logic mrs_n_q, prs_n_q, ser_en_q, ser_d_q, wr_en_q, rd_en_q, up_rdy_q, dn_v_q, irq_q, af_d_q;
    logic [17:0] wd_q, dn_q;
    logic [31:0] rd_q;
    logic wr_ctl;

    assign wr_ctl = we && addr == `MQF_A_CTRL;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_q <= `MQF_STRAP_RST;
            sel_q <= 18'h00000;
            flo_q <= 28'h0000000;
            fhi_q <= 14'h0000;
            mask_q <= 4'h0;
        end else if (we) begin
            case (addr)
                `MQF_A_CTRL: strap_q <= wdata[`MQF_CTRL_STRAP_LSB +: 6];
                `MQF_A_SEL: sel_q <= wdata[17:0];
                `MQF_A_FRM_LO: flo_q <= wdata[27:0];
                `MQF_A_FRM_HI: fhi_q <= wdata[13:0];
                `MQF_A_MASK: mask_q <= wdata[3:0];
                default: ;
            endcase
        end
    end

    assign ev[`MQF_ST_RESET] = st_q == mqf_pkg::st_mrst && mcnt_q == 3'h0;
    assign ev[`MQF_ST_FRAME] = st_q == mqf_pkg::st_shift && bit_q == `MQF_FRAME_LAST;
    assign ev[`MQF_ST_DROP] = up_valid && !up_rdy_q;
    assign ev[`MQF_ST_AF] = lnk.almost_full_flag && !af_d_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_q <= 4'h0;
            irq_q <= 1'b0;
            af_d_q <= 1'b0;
            rd_q <= 32'h00000000;
        end else begin
            af_d_q <= lnk.almost_full_flag;
            stat_q <= (stat_q & ~((we && addr == `MQF_A_STAT) ? wdata[3:0] : 4'h0)) | ev;
            irq_q <= |(stat_q & mask_q);
            rd_q <= 32'h00000000;
            if (re) begin
                case (addr)
                    `MQF_A_CTRL: rd_q <= {22'h0, strap_q, st_q != mqf_pkg::st_idle, 3'h0};
                    `MQF_A_SEL: rd_q <= {14'h0, sel_q};
                    `MQF_A_FRM_LO: rd_q <= {4'h0, flo_q};
                    `MQF_A_FRM_HI: rd_q <= {18'h0, fhi_q};
                    `MQF_A_STAT: rd_q <= {28'h0, stat_q};
                    `MQF_A_MASK: rd_q <= {28'h0, mask_q};
                    `MQF_A_FLAGS: rd_q <= {10'h0, lnk.ae_sector, lnk.af_sector, lnk.ae_bus, lnk.af_bus,
                                           lnk.almost_empty_flag, lnk.output_valid_flag,
                                           lnk.almost_full_flag, lnk.queue_full_flag};
                    default: rd_q <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Reset and serial programming sequencer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= mqf_pkg::st_idle;
            mrs_n_q <= 1'b1;
            prs_n_q <= 1'b1;
            ser_en_q <= 1'b0;
            ser_d_q <= 1'b0;
            sh_q <= 42'h0;
            bit_q <= 6'h00;
            mcnt_q <= 3'h0;
        end else begin
            prs_n_q <= !(wr_ctl && wdata[`MQF_CTRL_PRS] && st_q == mqf_pkg::st_idle);
            case (st_q)
                mqf_pkg::st_idle: begin
                    ser_en_q <= 1'b0;
                    if (wr_ctl && wdata[`MQF_CTRL_MRS]) begin
                        st_q <= mqf_pkg::st_mrst;
                        mrs_n_q <= 1'b0;
                        mcnt_q <= `MQF_MRS_CYC - 3'h1;
                    end else if (wr_ctl && wdata[`MQF_CTRL_SEND]) begin
                        st_q <= mqf_pkg::st_shift;
                        sh_q <= {fhi_q, flo_q};
                        bit_q <= 6'h00;
                    end
                end
                mqf_pkg::st_mrst: begin
                    if (mcnt_q == 3'h0) begin
                        mrs_n_q <= 1'b1;
                        st_q <= mqf_pkg::st_idle;
                    end else begin
                        mcnt_q <= mcnt_q - 3'h1;
                    end
                end
                mqf_pkg::st_shift: begin
                    ser_en_q <= 1'b1;
                    ser_d_q <= sh_q[41];
                    sh_q <= {sh_q[40:0], 1'b0};
                    bit_q <= bit_q + 6'h01;
                    if (bit_q == `MQF_FRAME_LAST) begin
                        st_q <= mqf_pkg::st_idle;
                    end
                end
                default: st_q <= mqf_pkg::st_idle;
            endcase
        end
    end

    // ----------------------------------------
    // Stream ports
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_en_q <= 1'b0;
            wd_q <= 18'h00000;
            rd_en_q <= 1'b0;
            up_rdy_q <= 1'b0;
            dn_q <= 18'h00000;
            dn_v_q <= 1'b0;
        end else begin
            up_rdy_q <= !lnk.queue_full_flag && mrs_n_q;
            wr_en_q <= up_valid && up_rdy_q;
            wd_q <= up_data;
            rd_en_q <= dn_ready && mrs_n_q;
            dn_v_q <= rd_en_q && lnk.output_valid_flag;
            dn_q <= lnk.rd_data;
        end
    end

    assign lnk.master_reset_n = mrs_n_q;
    assign lnk.partial_reset_n = prs_n_q;
    assign {lnk.cfg_dev_id, lnk.cfg_polled, lnk.cfg_out_wide, lnk.cfg_in_wide} = strap_q;
    assign lnk.ser_en = ser_en_q;
    assign lnk.ser_data = ser_d_q;
    assign lnk.write_queue_select = sel_q[6:0];
    assign lnk.read_queue_select = sel_q[14:8];
    assign lnk.af_sector_sel = sel_q[16];
    assign lnk.ae_sector_sel = sel_q[17];
    assign lnk.wr_en = wr_en_q;
    assign lnk.wr_data = wd_q;
    assign lnk.rd_en = rd_en_q;
    assign rdata = rd_q;
    assign irq = irq_q;
    assign up_ready = up_rdy_q;
    assign dn_data = dn_q;
    assign dn_valid = dn_v_q;
endmodule // mqf_host
`default_nettype wire

/* testbench/mqf_link_assertions.sv */
// Checker on the signals between the two queue-link ends
// Assumes tb_top wires it beside the link, device id kept at 0
`timescale 1ns/1ps
`default_nettype none
module mqf_link_assertions (
    input wire logic clk, // Clock
    input wire logic rstn, // Reset, low
    input wire logic master_reset_n, // Master reset
    input wire logic partial_reset_n, // Partial reset
    input wire logic ser_en, // Frame on
    input wire logic cfg_polled, // Polled bus
    input wire logic [2:0] cfg_dev_id, // Id
    input wire logic [6:0] write_queue_select, // Write queue
    input wire logic [6:0] read_queue_select, // Read queue
    input wire logic queue_full_flag, // Full
    input wire logic almost_full_flag, // Almost full
    input wire logic output_valid_flag, // Valid
    input wire logic almost_empty_flag, // Almost empty
    input wire logic af_sector // Bus sector
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence mrs_hold_s;
        !master_reset_n [*4] ##1 master_reset_n;
    endsequence
    mrs_hold_a: assert property ($fell(master_reset_n) |-> mrs_hold_s)
        else $error("master reset length");
    prs_pulse_a: assert property ($fell(partial_reset_n) |=> partial_reset_n)
        else $error("partial reset length");
    frame_in_mrs_a: assert property (!master_reset_n |-> !ser_en)
        else $error("frame in master reset");
    full_away_a: assert property ($stable(write_queue_select) && write_queue_select[6:4] != cfg_dev_id
        |=> queue_full_flag) else $error("full low off device");
    af_away_a: assert property ($stable(write_queue_select) && write_queue_select[6:4] != cfg_dev_id
        |=> almost_full_flag) else $error("af low off device");
    ov_away_a: assert property ($stable(read_queue_select) && read_queue_select[6:4] != cfg_dev_id
        |=> !output_valid_flag) else $error("valid off device");
    ae_away_a: assert property ($stable(read_queue_select) && read_queue_select[6:4] != cfg_dev_id
        |=> almost_empty_flag) else $error("ae low off device");
    poll_step_a: assert property (cfg_polled && af_sector |=> !af_sector)
        else $error("sector stuck");
endmodule // mqf_link_assertions
`default_nettype wire

/* testbench/tb_top.sv */
// Bench joining both link ends against a queue model
// Assumes design, link and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 0, rstn = 0, we = 0, re = 0, up_valid = 0, dn_ready = 0, irq, up_ready, dn_valid;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [17:0] up_data = 18'h0, dn_data;
    logic prog_ok;
    logic [4:0] queue_count;
    int num_errors = 0, check_count = 0;
    logic [17:0] exp_q[$];
    mqf_link_if lnk();
    mqf_device i_mqf_device(.clk(clk), .rstn(rstn), .lnk(lnk.dev), .prog_ok(prog_ok), .queue_count(queue_count));
    mqf_host i_mqf_host(.clk(clk), .rstn(rstn), .lnk(lnk.host), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata(rdata), .irq(irq), .up_valid(up_valid), .up_data(up_data), .up_ready(up_ready),
        .dn_ready(dn_ready), .dn_data(dn_data), .dn_valid(dn_valid));
    mqf_link_assertions i_mqf_link_assertions(.clk(clk), .rstn(rstn), .master_reset_n(lnk.master_reset_n),
        .partial_reset_n(lnk.partial_reset_n), .ser_en(lnk.ser_en), .cfg_polled(lnk.cfg_polled),
        .cfg_dev_id(lnk.cfg_dev_id), .write_queue_select(lnk.write_queue_select),
        .read_queue_select(lnk.read_queue_select), .queue_full_flag(lnk.queue_full_flag),
        .almost_full_flag(lnk.almost_full_flag), .output_valid_flag(lnk.output_valid_flag),
        .almost_empty_flag(lnk.almost_empty_flag), .af_sector(lnk.af_sector));
    always #4 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk(rdata & m, e, nm);
        @(posedge clk);
    endtask
    // Random offers, drain only when allowed
    task automatic push(input int n, input logic drain);
        repeat (n) begin
            up_valid <= 1'($urandom);
            up_data <= 18'($urandom);
            dn_ready <= drain & 1'($urandom);
            @(posedge clk);
        end
        up_valid <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (up_valid && up_ready) exp_q.push_back(up_data);
        if (dn_valid) begin
            chk(exp_q.size() != 0, 1, "extra_word");
            if (exp_q.size() != 0) chk(dn_data, exp_q.pop_front(), "dn_data");
        end
    end
    initial begin
        void'($urandom(37));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(5'h1c, 32'hffffffff, 32'h0, "unmapped");
        wr(5'h14, 32'h1);
        wr(5'h00, 32'h71);
        repeat (8) @(posedge clk);
        chk(irq, 1'b1, "irq_set");
        chk(prog_ok, 1'b1, "prog_ok");
        chk(queue_count, 32'h10, "def_count");
        rd(5'h00, 32'h3f0, 32'h70, "straps");
        wr(5'h10, 32'h1);
        @(posedge clk);
        chk(irq, 1'b0, "irq_clr");
        wr(5'h04, 32'h1313);
        repeat (2) @(posedge clk);
        rd(5'h18, 32'hf, 32'hb, "away_flags");
        wr(5'h04, 32'h0303);
        push(40, 1'b1);
        dn_ready <= 1'b1;
        repeat (20) @(posedge clk);
        chk(exp_q.size(), 0, "drained");
        push(6, 1'b0);
        wr(5'h04, 32'h0304);
        wr(5'h00, 32'h72);
        wr(5'h04, 32'h0303);
        dn_ready <= 1'b1;
        repeat (20) @(posedge clk);
        chk(exp_q.size(), 0, "prs_ignored");
        push(6, 1'b0);
        repeat (4) @(posedge clk);
        wr(5'h00, 32'h72);
        exp_q.delete();
        rd(5'h18, 32'hc, 32'h8, "prs_clear");
        dn_ready <= 1'b1;
        repeat (10) @(posedge clk);
        // Serial frame: four queues, queue 0 one block
        wr(5'h08, 32'h0);
        wr(5'h0c, 32'h801);
        wr(5'h00, 32'h74);
        repeat (46) @(posedge clk);
        chk(queue_count, 32'h4, "frame_count");
        rd(5'h10, 32'h2, 32'h2, "frame_done");
        end_of_test();
    end
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
